// File: hw/mcc_pkg.sv
// constants, types and state layout of the core control block
// What this block does
// - program space is 6K words in six 1K pages
// - after any reset the 13-bit program counter is zero
// - every interrupt source shares the vector at address 0x0001
// - interrupt entry saves status, RAM select, extra switch, accumulator; clears page
// - interrupt return restores context, pops stack, re-enables interrupts
// - irq enable register reachable only by control read and write operations
// - indirect port has no storage; it accesses the address in RAM select
// - 8-bit tick counter, read/write, increments after each instruction cycle
// - tick wrap FFh to 00h sets overflow flag bit 0 and raises timer irq
// - clearing enable bit 0 suppresses the timer interrupt request
// - power-on and watchdog reset load the tick counter with 0x00
// - pc low byte visible in pc register; page bits supply upper bits; 8-deep stack
// - power-on and watchdog reset clear the program counter
// - status: page 7..5, time-out 4, power-down 3, zero 2, half carry 1, carry 0
// - carry is carry out of top bit, inverted for borrow, shifted bit for rotates
// - half carry is carry out of low nibble, inverted for borrow
// - zero flag set when an arithmetic or logic result is zero
// - power-down mark set at power-on or watchdog clear, cleared by sleep, kept by watchdog
// - time-out flag set at power-on or watchdog clear, cleared on watchdog time-out
// - page codes 0..5 select pages at code times 0x400
// - RAM select low six bits address 0x00..0x3f, top two bits select bank
package mcc_pkg;
  // ********************
  // data space map
  // ********************
  localparam logic [5:0] MCC_A_INDIRECT = 6'h00;
  localparam logic [5:0] MCC_A_TICK = 6'h01;
  localparam logic [5:0] MCC_A_PCLOW = 6'h02;
  localparam logic [5:0] MCC_A_STATUS = 6'h03;
  localparam logic [5:0] MCC_A_RAMSEL = 6'h04;
  localparam logic [5:0] MCC_A_EXTRA = 6'h08;
  localparam logic [5:0] MCC_A_IRQFLAG = 6'h0f;
  localparam logic [5:0] MCC_C_IRQEN = 6'h0f;
  localparam logic [5:0] MCC_COMMON_TOP = 6'h1f;
  // ********************
  // status fields and reset values
  // ********************
  localparam int MCC_S_C = 0;
  localparam int MCC_S_HC = 1;
  localparam int MCC_S_Z = 2;
  localparam int MCC_S_P = 3;
  localparam int MCC_S_T = 4;
  localparam int MCC_EXTRA_BIT = 7;
  localparam logic [7:0] MCC_STATUS_RST = 8'h18;
  localparam logic [2:0] MCC_PAGE_LAST = 3'h5;
  localparam logic [12:0] MCC_VECTOR = 13'h0001;
  localparam logic [12:0] MCC_PC_RST = 13'h0000;
  localparam logic [7:0] MCC_TICK_RST = 8'h00;
  localparam logic [7:0] MCC_TICK_MAX = 8'hff;
  localparam logic [7:0] MCC_IRQ_MASK = 8'h9f;
  // ********************
  // types
  // ********************
  typedef enum logic [3:0] {
    MCC_STEP = 4'h0, MCC_JUMP = 4'h1, MCC_CALL = 4'h2, MCC_RET = 4'h3,
    MCC_IRQ_RET = 4'h4, MCC_DRD = 4'h5, MCC_DWR = 4'h6, MCC_CRD = 4'h7,
    MCC_CWR = 4'h8, MCC_WDOG_CLR = 4'h9, MCC_SLEEP = 4'ha, MCC_ADD = 4'hb,
    MCC_SUB = 4'hc, MCC_LOGIC = 4'hd, MCC_RRC = 4'he, MCC_RLC = 4'hf
  } mcc_kind_e;
  typedef struct packed {
    logic valid;
    mcc_kind_e kind;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] operand;
    logic [9:0] target;
    logic [7:0] acc;
  } mcc_req_s;
  typedef struct packed {
    logic rd_valid;
    logic [7:0] rd_data;
    logic ext_valid;
    logic ext_we;
    logic [8:0] ext_addr;
    logic [7:0] ext_wdata;
    logic acc_load;
    logic [7:0] acc_data;
  } mcc_rsp_s;
  typedef struct packed {
    logic [12:0] pc;
    logic [7:0][12:0] stack;
    logic [2:0] sp;
    logic [7:0] tick;
    logic [7:0] status;
    logic [7:0] ram_sel;
    logic extra;
    logic [7:0] irq_flag;
    logic [7:0] irq_en;
    logic gie;
    logic irq_req;
    logic [7:0] sv_status;
    logic [7:0] sv_ram_sel;
    logic sv_extra;
    logic [7:0] sv_acc;
    mcc_rsp_s rsp;
  } mcc_state_s;
endpackage : mcc_pkg

// File: hw/mcc_core.sv
// core control: program counter, stack, interrupt entry, tick counter, status
`timescale 1ns/100ps
`default_nettype none
module mcc_core
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic wdt_rst,
  input wire mcc_pkg::mcc_req_s req,
  input wire logic [4:0] irq_src,
  output logic [12:0] pc,
  output logic [7:0] status,
  output logic irq_req,
  output mcc_pkg::mcc_rsp_s rsp
);
  import mcc_pkg::*;

  mcc_state_s q;
  mcc_state_s d;
  logic [5:0] eff;
  logic [12:0] next_pc;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [7:0] res;
  logic take;
  logic tick_wr;
  logic wrap;

  // ********************
  // next state
  // ********************
  always_comb
  begin
    d = q;
    d.rsp.rd_valid = 1'b0;
    d.rsp.ext_valid = 1'b0;
    d.rsp.ext_we = 1'b0;
    d.rsp.acc_load = 1'b0;
    eff = (req.addr == MCC_A_INDIRECT) ? q.ram_sel[5:0] : req.addr;
    next_pc = q.pc + 13'h0001;
    sum9 = 9'h000;
    nib5 = 5'h00;
    res = 8'h00;
    tick_wr = req.valid && req.kind == MCC_DWR && eff == MCC_A_TICK;
    wrap = req.valid && !tick_wr && q.tick == MCC_TICK_MAX;
    take = req.valid && q.gie && q.irq_req && !wdt_rst
      && !(req.kind inside {MCC_JUMP, MCC_CALL, MCC_RET, MCC_IRQ_RET});
    if (req.valid)
    begin
      d.tick = q.tick + 8'h01;
      unique case (req.kind)
        MCC_STEP: ;
        MCC_JUMP: next_pc = {q.status[7:5], req.target};
        MCC_CALL:
        begin
          d.stack[q.sp] = next_pc;
          d.sp = q.sp + 3'h1;
          next_pc = {q.status[7:5], req.target};
        end
        MCC_RET, MCC_IRQ_RET:
        begin
          d.sp = q.sp - 3'h1;
          next_pc = q.stack[d.sp];
          if (req.kind == MCC_IRQ_RET)
          begin
            d.status = q.sv_status;
            d.ram_sel = q.sv_ram_sel;
            d.extra = q.sv_extra;
            d.rsp.acc_load = 1'b1;
            d.rsp.acc_data = q.sv_acc;
            d.gie = 1'b1;
          end
        end
        MCC_DRD:
        begin
          d.rsp.rd_valid = 1'b1;
          unique case (eff)
            MCC_A_INDIRECT: d.rsp.rd_data = 8'h00;
            MCC_A_TICK: d.rsp.rd_data = q.tick;
            MCC_A_PCLOW: d.rsp.rd_data = q.pc[7:0];
            MCC_A_STATUS: d.rsp.rd_data = q.status;
            MCC_A_RAMSEL: d.rsp.rd_data = q.ram_sel;
            MCC_A_EXTRA: d.rsp.rd_data = {q.extra, 7'h00};
            MCC_A_IRQFLAG: d.rsp.rd_data = q.irq_flag;
            default:
            begin
              d.rsp.rd_valid = 1'b0;
              d.rsp.ext_valid = 1'b1;
            end
          endcase
        end
        MCC_DWR:
        begin
          unique case (eff)
            MCC_A_INDIRECT: ;
            MCC_A_TICK: d.tick = req.wdata;
            MCC_A_PCLOW: next_pc = {q.status[7:5], q.pc[9:8], req.wdata};
            MCC_A_STATUS:
            begin
              d.status[2:0] = req.wdata[2:0];
              if (req.wdata[7:5] <= MCC_PAGE_LAST)
                d.status[7:5] = req.wdata[7:5];
            end
            MCC_A_RAMSEL: d.ram_sel = req.wdata;
            MCC_A_EXTRA: d.extra = req.wdata[MCC_EXTRA_BIT];
            MCC_A_IRQFLAG: d.irq_flag = req.wdata & MCC_IRQ_MASK;
            default:
            begin
              d.rsp.ext_valid = 1'b1;
              d.rsp.ext_we = 1'b1;
            end
          endcase
        end
        MCC_CRD:
        begin
          d.rsp.rd_valid = 1'b1;
          d.rsp.rd_data = (req.addr == MCC_C_IRQEN) ? q.irq_en : 8'h00;
        end
        MCC_CWR:
          if (req.addr == MCC_C_IRQEN)
            d.irq_en = req.wdata;
        MCC_WDOG_CLR:
        begin
          d.status[MCC_S_T] = 1'b1;
          d.status[MCC_S_P] = 1'b1;
        end
        MCC_SLEEP: d.status[MCC_S_P] = 1'b0;
        MCC_ADD:
        begin
          sum9 = {1'b0, req.wdata} + {1'b0, req.operand};
          nib5 = {1'b0, req.wdata[3:0]} + {1'b0, req.operand[3:0]};
          res = sum9[7:0];
          d.status[MCC_S_C] = sum9[8];
          d.status[MCC_S_HC] = nib5[4];
        end
        MCC_SUB:
        begin
          sum9 = {1'b0, req.wdata} - {1'b0, req.operand};
          nib5 = {1'b0, req.wdata[3:0]} - {1'b0, req.operand[3:0]};
          res = sum9[7:0];
          d.status[MCC_S_C] = ~sum9[8];
          d.status[MCC_S_HC] = ~nib5[4];
        end
        MCC_LOGIC: res = req.wdata;
        MCC_RRC:
        begin
          res = {q.status[MCC_S_C], req.wdata[7:1]};
          d.status[MCC_S_C] = req.wdata[0];
        end
        MCC_RLC:
        begin
          res = {req.wdata[6:0], q.status[MCC_S_C]};
          d.status[MCC_S_C] = req.wdata[7];
        end
      endcase
      if (req.kind inside {MCC_ADD, MCC_SUB, MCC_LOGIC})
        d.status[MCC_S_Z] = (res == 8'h00);
      if (req.kind inside {MCC_ADD, MCC_SUB, MCC_LOGIC, MCC_RRC, MCC_RLC})
      begin
        d.rsp.rd_valid = 1'b1;
        d.rsp.rd_data = res;
      end
      if (wrap)
        d.irq_flag[0] = 1'b1;
      d.rsp.ext_addr = {q.extra, q.ram_sel[7:6], eff};
      if (eff <= MCC_COMMON_TOP)
        d.rsp.ext_addr[8:6] = 3'h0;
      d.rsp.ext_wdata = req.wdata;
      d.pc = next_pc;
      if (take)
      begin
        d.stack[q.sp] = next_pc;
        d.sp = q.sp + 3'h1;
        d.sv_status = d.status;
        d.sv_ram_sel = d.ram_sel;
        d.sv_extra = d.extra;
        d.sv_acc = req.acc;
        d.status[7:5] = 3'h0;
        d.pc = MCC_VECTOR;
        d.gie = 1'b0;
      end
    end
    // events set after writes so a set wins over a clear
    d.irq_flag = d.irq_flag | {irq_src[4], 2'b00, irq_src[3:0], 1'b0};
    d.irq_req = |(d.irq_flag & d.irq_en & MCC_IRQ_MASK);
    if (wdt_rst)
    begin
      d.pc = MCC_PC_RST;
      d.tick = MCC_TICK_RST;
      d.status[7:5] = 3'h0;
      d.status[MCC_S_T] = 1'b0;
      d.gie = 1'b1;
      d.rsp = '0;
    end
    if (!rst_b)
    begin
      d = '0;
      d.pc = MCC_PC_RST;
      d.tick = MCC_TICK_RST;
      d.status = MCC_STATUS_RST;
      d.gie = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    q <= d;
  end

  assign pc = q.pc;
  assign status = q.status;
  assign irq_req = q.irq_req;
  assign rsp = q.rsp;

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_reset_pc_zero: assert property ($rose(rst_b) |-> q.pc == 13'h0000 && q.tick == 8'h00)
    else $error("pc or tick not zero after reset");
  a_tick_counts_up: assert property (req.valid && !wdt_rst && !tick_wr
      |=> q.tick == $past(q.tick) + 8'h01)
    else $error("tick did not advance");
  a_tick_wrap_flag: assert property (req.valid && !wdt_rst && !tick_wr && q.tick == 8'hff
      |=> q.irq_flag[0] && (q.irq_req || !q.irq_en[0]))
    else $error("tick wrap did not flag");
  a_mask_gates_req: assert property (q.irq_req |-> |(q.irq_flag & q.irq_en & MCC_IRQ_MASK))
    else $error("request without enabled flag");
  a_irq_entry_vec: assert property (take |=> q.pc == MCC_VECTOR && q.status[7:5] == 3'h0
      && !q.gie)
    else $error("interrupt entry wrong");
  a_irq_ret_restore: assert property (req.valid && req.kind == MCC_IRQ_RET && !wdt_rst
      |=> q.gie && q.rsp.acc_load && q.status == $past(q.sv_status))
    else $error("interrupt return wrong");
  a_wdt_clears: assert property (wdt_rst |=> q.pc == 13'h0000 && q.tick == 8'h00
      && !q.status[MCC_S_T] && q.status[MCC_S_P] == $past(q.status[MCC_S_P]))
    else $error("watchdog reset wrong");
  a_sleep_clears_pd: assert property (req.valid && req.kind == MCC_SLEEP && !wdt_rst
      |=> !q.status[MCC_S_P])
    else $error("sleep kept power-down mark");
  a_add_zero_flag: assert property (req.valid && req.kind == MCC_ADD && !wdt_rst
      |=> q.status[MCC_S_Z] == (q.rsp.rd_data == 8'h00))
    else $error("zero flag mismatch");
  a_page_in_range: assert property (q.status[7:5] <= MCC_PAGE_LAST)
    else $error("page code out of range");
  a_no_nested_irq: assert property (!q.gie && req.valid && req.kind == MCC_STEP && !wdt_rst
      |=> !q.gie && $stable(q.sv_status) && $stable(q.sv_acc))
    else $error("saved context overwritten");

  // ********************
  // program flow and status checks
  // ********************
  a_reset_status: assert property ($rose(rst_b)
      |-> q.status == MCC_STATUS_RST && !q.irq_req)
    else $error("status not at reset value");
  a_pc_steps: assert property (req.valid && req.kind == MCC_STEP && !take && !wdt_rst
      |=> q.pc == $past(q.pc) + 13'h0001)
    else $error("pc did not step");
  a_call_push: assert property (req.valid && req.kind == MCC_CALL && !wdt_rst
      |=> q.sp == $past(q.sp) + 3'h1 && q.pc[9:0] == $past(req.target))
    else $error("call did not push");
  a_ret_pop: assert property (req.valid && req.kind == MCC_RET && !wdt_rst
      |=> q.sp == $past(q.sp) - 3'h1)
    else $error("return did not pop");
  a_pclow_write: assert property (req.valid && req.kind == MCC_DWR && eff == MCC_A_PCLOW
      && !take && !wdt_rst |=> q.pc[7:0] == $past(req.wdata))
    else $error("pc low write lost");
  a_wdog_clear_flags: assert property (req.valid && req.kind == MCC_WDOG_CLR && !wdt_rst
      |=> q.status[MCC_S_T] && q.status[MCC_S_P])
    else $error("watchdog clear kept flags low");

  // ********************
  // data routing checks
  // ********************
  a_indirect_route: assert property (req.valid && req.kind inside {MCC_DRD, MCC_DWR}
      && req.addr == MCC_A_INDIRECT && q.ram_sel[5:0] > MCC_COMMON_TOP && !wdt_rst
      |=> q.rsp.ext_valid && q.rsp.ext_addr[5:0] == $past(q.ram_sel[5:0]))
    else $error("indirect access misrouted");
  a_ctrl_en_only: assert property (req.valid && req.kind == MCC_DWR && !wdt_rst
      |=> $stable(q.irq_en))
    else $error("data write changed irq enable");
  a_bank_common: assert property (q.rsp.ext_valid && q.rsp.ext_addr[5:0] <= MCC_COMMON_TOP
      |-> q.rsp.ext_addr[8:6] == 3'h0)
    else $error("common address carries a bank");

  // ********************
  // flag and arithmetic checks
  // ********************
  a_src_sets_flag: assert property (irq_src[3] |=> q.irq_flag[4])
    else $error("source event not flagged");
  a_sub_carry: assert property (req.valid && req.kind == MCC_SUB && !wdt_rst
      |=> q.status[MCC_S_C] == ($past(req.wdata) >= $past(req.operand)))
    else $error("borrow flag wrong");
  a_add_half: assert property (req.valid && req.kind == MCC_ADD && !wdt_rst
      |=> q.status[MCC_S_HC] == ($past(req.wdata[3:0]) + $past(req.operand[3:0]) > 5'h0f))
    else $error("half carry wrong");

  c_irq_taken: cover property (take);
  c_irq_return: cover property (req.valid && req.kind == MCC_IRQ_RET);
  c_wdog_event: cover property (wdt_rst);
  c_tick_wrap: cover property (req.valid && q.tick == 8'hff);
  c_call_ret: cover property (req.valid && req.kind == MCC_CALL ##[1:20] req.valid && req.kind == MCC_RET);
endmodule : mcc_core
`default_nettype wire

// File: testbench/tb_mcc_core.sv
// self-checking bench for the core control block
`timescale 1ns/100ps
`default_nettype none
module tb_mcc_core;
  import mcc_pkg::*;
  // ********************
  // stimulus and design
  // ********************
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic wdt_rst = 1'b0;
  mcc_req_s req = '0;
  logic [4:0] irq_src = 5'h00;
  logic [12:0] pc;
  logic [7:0] status;
  logic irq_req;
  mcc_rsp_s rsp;
  int num_errors = 0;
  int compares = 0;
  always #25 clock = ~clock;
  mcc_core mcc_core_i
  (
    .clock(clock),
    .rst_b(rst_b),
    .wdt_rst(wdt_rst),
    .req(req),
    .irq_src(irq_src),
    .pc(pc),
    .status(status),
    .irq_req(irq_req),
    .rsp(rsp)
  );
  // ********************
  // tasks
  // ********************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one instruction, answer settled one cycle later
  task automatic op(input mcc_kind_e k, input logic [5:0] a, input logic [7:0] d,
                    input logic [7:0] o);
    @(posedge clock);
    req <= '{1'b1, k, a, d, o, 10'h123, 8'h3c};
    @(posedge clock);
    req.valid <= 1'b0;
    #1;
  endtask : op
  task automatic alu(input mcc_kind_e k, input logic [7:0] d, input logic [7:0] o,
                     input logic [7:0] r, input logic [2:0] f);
    op(k, 6'h10, d, o);
    chk("alu_result", {8'h00, r}, {8'h00, rsp.rd_data});
    chk("alu_flags", {13'h0000, f}, {13'h0000, status[2:0]});
  endtask : alu
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // ********************
  // sequence
  // ********************
  initial
  begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    chk("pc", 16'h0000, {3'b000, pc});
    chk("status", 16'h0018, {8'h00, status});
    chk("irq_req", 16'h0000, {15'h0000, irq_req});
    done("reset");
    alu(MCC_ADD, 8'h0f, 8'h01, 8'h10, 3'b010);
    alu(MCC_ADD, 8'hff, 8'h01, 8'h00, 3'b111);
    alu(MCC_SUB, 8'h03, 8'h05, 8'hfe, 3'b000);
    alu(MCC_RRC, 8'h01, 8'h00, 8'h00, 3'b001);
    alu(MCC_RLC, 8'h80, 8'h00, 8'h01, 3'b001);
    alu(MCC_SUB, 8'h07, 8'h07, 8'h00, 3'b111);
    done("alu");
    op(MCC_DWR, MCC_A_TICK, 8'hfe, 8'h00);
    op(MCC_DRD, MCC_A_TICK, 8'h00, 8'h00);
    chk("tick", 16'h00fe, {8'h00, rsp.rd_data});
    op(MCC_STEP, 6'h10, 8'h00, 8'h00);
    op(MCC_DRD, MCC_A_IRQFLAG, 8'h00, 8'h00);
    chk("irq_flag", 16'h0001, {8'h00, rsp.rd_data});
    chk("irq_req", 16'h0000, {15'h0000, irq_req});
    done("tick");
    op(MCC_DWR, MCC_A_STATUS, 8'ha7, 8'h00);
    chk("status", 16'h00bf, {8'h00, status});
    op(MCC_DWR, MCC_A_STATUS, 8'hc0, 8'h00);
    chk("status", 16'h00b8, {8'h00, status});
    op(MCC_JUMP, 6'h10, 8'h00, 8'h00);
    chk("pc", 16'h1523, {3'b000, pc});
    op(MCC_CWR, MCC_C_IRQEN, 8'h01, 8'h00);
    chk("irq_req", 16'h0001, {15'h0000, irq_req});
    op(MCC_STEP, 6'h10, 8'h00, 8'h00);
    chk("pc", 16'h0001, {3'b000, pc});
    chk("status", 16'h0018, {8'h00, status});
    op(MCC_STEP, 6'h10, 8'h00, 8'h00);
    chk("pc", 16'h0002, {3'b000, pc});
    op(MCC_DWR, MCC_A_IRQFLAG, 8'h00, 8'h00);
    chk("irq_req", 16'h0000, {15'h0000, irq_req});
    op(MCC_CRD, MCC_C_IRQEN, 8'h00, 8'h00);
    chk("irq_en", 16'h0001, {8'h00, rsp.rd_data});
    op(MCC_IRQ_RET, 6'h10, 8'h00, 8'h00);
    chk("pc", 16'h1525, {3'b000, pc});
    chk("status", 16'h00b8, {8'h00, status});
    chk("acc_load", 16'h0001, {15'h0000, rsp.acc_load});
    chk("acc_data", 16'h003c, {8'h00, rsp.acc_data});
    done("interrupt");
    op(MCC_DWR, MCC_A_RAMSEL, 8'ha5, 8'h00);
    op(MCC_DWR, MCC_A_INDIRECT, 8'h5a, 8'h00);
    chk("ext_valid", 16'h0001, {15'h0000, rsp.ext_valid});
    chk("ext_we", 16'h0001, {15'h0000, rsp.ext_we});
    chk("ext_addr", 16'h00a5, {7'h00, rsp.ext_addr});
    chk("ext_wdata", 16'h005a, {8'h00, rsp.ext_wdata});
    done("indirect");
    @(posedge clock);
    wdt_rst <= 1'b1;
    @(posedge clock);
    wdt_rst <= 1'b0;
    #1;
    chk("pc", 16'h0000, {3'b000, pc});
    chk("status", 16'h0008, {8'h00, status});
    op(MCC_DRD, MCC_A_TICK, 8'h00, 8'h00);
    chk("tick", 16'h0000, {8'h00, rsp.rd_data});
    @(posedge clock);
    irq_src <= 5'h08;
    @(posedge clock);
    irq_src <= 5'h00;
    op(MCC_DRD, MCC_A_IRQFLAG, 8'h00, 8'h00);
    chk("irq_flag", 16'h0010, {8'h00, rsp.rd_data});
    op(MCC_WDOG_CLR, 6'h10, 8'h00, 8'h00);
    chk("status_tp", 16'h0003, {14'h0000, status[4:3]});
    op(MCC_SLEEP, 6'h10, 8'h00, 8'h00);
    chk("status_tp", 16'h0002, {14'h0000, status[4:3]});
    done("watchdog");
    op(MCC_CALL, 6'h10, 8'h00, 8'h00);
    chk("pc", 16'h0123, {3'b000, pc});
    op(MCC_DWR, MCC_A_PCLOW, 8'h40, 8'h00);
    chk("pc", 16'h0140, {3'b000, pc});
    op(MCC_DRD, MCC_A_PCLOW, 8'h00, 8'h00);
    chk("rd_valid", 16'h0001, {15'h0000, rsp.rd_valid});
    chk("pc_low", 16'h0040, {8'h00, rsp.rd_data});
    op(MCC_RET, 6'h10, 8'h00, 8'h00);
    chk("pc", 16'h0005, {3'b000, pc});
    alu(MCC_LOGIC, 8'h00, 8'h00, 8'h00, 3'b100);
    done("flow");
    op(MCC_DWR, MCC_A_EXTRA, 8'h80, 8'h00);
    op(MCC_DRD, MCC_A_INDIRECT, 8'h00, 8'h00);
    chk("ext_valid", 16'h0001, {15'h0000, rsp.ext_valid});
    chk("ext_we", 16'h0000, {15'h0000, rsp.ext_we});
    chk("ext_addr", 16'h01a5, {7'h00, rsp.ext_addr});
    op(MCC_DRD, 6'h10, 8'h00, 8'h00);
    chk("ext_addr", 16'h0010, {7'h00, rsp.ext_addr});
    done("bank");
    wrap_up();
  end
  // hang guard
  initial
  begin
    repeat (3000) @(posedge clock);
    num_errors++;
    wrap_up();
  end
endmodule : tb_mcc_core
`default_nettype wire
